// [rtl/pxb_pkg.sv]
// package for the port pin control and priority crossbar
package pxb_pkg;
  // pin population: P0.0..P2.4
  localparam int NUM_PINS      = 21;
  localparam int XBAR_PINS     = 20;   // P0.0..P2.3 crossbar-managed
  localparam int GPIO_ONLY_PIN = 20;   // P2.4, shared with debug_data_line
  // fixed serial port pins
  localparam int UART_TX_PIN   = 4;
  localparam int UART_RX_PIN   = 5;
  // fixed analog functions
  localparam int REF_PIN       = 0;
  localparam int IOUT_PIN      = 1;
  localparam int XTAL_IN_PIN   = 2;
  localparam int XTAL_OUT_PIN  = 3;
  // crossbar slot numbering, in priority order after the serial port
  localparam int SLOT_SPI_SCK  = 0;
  localparam int SLOT_SPI_MISO = 1;
  localparam int SLOT_SPI_MOSI = 2;
  localparam int SLOT_SPI_NSS  = 3;
  localparam int SLOT_SMB0_SDA = 4;
  localparam int SLOT_SMB0_SCL = 5;
  localparam int SLOT_CP0      = 6;
  localparam int SLOT_COMPARATOR_ASYNC_OUTPUT     = 7;
  localparam int SLOT_SYSCLK   = 8;
  localparam int SLOT_CEX0     = 9;
  localparam int SLOT_CEX1     = 10;
  localparam int SLOT_CEX2     = 11;
  localparam int SLOT_ECI      = 12;
  localparam int SLOT_T0       = 13;
  localparam int SLOT_T1       = 14;
  localparam int SLOT_SMB1_SDA = 15;
  localparam int SLOT_SMB1_SCL = 16;
  localparam int NUM_SLOTS     = 17;
  // reset values
  localparam logic [NUM_PINS-1:0] INPUT_KIND_RESET = '1;  // digital
  localparam logic [NUM_PINS-1:0] DRIVE_RESET      = '0;  // open-drain
  localparam logic [NUM_PINS-1:0] LATCH_RESET      = '1;  // released
  localparam logic [NUM_PINS-1:0] BYPASS_RESET     = '0;
  // pin index field width
  localparam int PIN_IDX_W     = 5;
endpackage

// [rtl/pxb_port_io.sv]
// port pin cells, priority crossbar and event pin reach
// ***********************************************
// port pin control with priority crossbar
// ***********************************************
module pxb_port_io #(
  parameter int P_NUM_PINS = pxb_pkg::NUM_PINS
) (
  // clock and reset
  input  wire logic                           i_clock,
  input  wire logic                           i_rstn,
  // configuration from software
  input  wire logic [P_NUM_PINS-1:0]          i_pin_input_kind_select,
  input  wire logic [P_NUM_PINS-1:0]          i_pin_drive_style_select,
  input  wire logic [P_NUM_PINS-1:0]          i_pin_bypass_mask,
  input  wire logic                           i_cfg_write,
  input  wire logic [P_NUM_PINS-1:0]          i_port_latch_wdata,
  input  wire logic                           i_latch_write,
  input  wire logic                           i_crossbar_route_enable,
  input  wire logic                           i_global_pullup_off,
  input  wire logic                           i_uart_enable,
  input  wire logic                           i_spi_enable,
  input  wire logic                           i_spi_four_wire,
  input  wire logic                           i_smb0_enable,
  input  wire logic                           i_smb1_enable,
  input  wire logic                           i_cp0_enable,
  input  wire logic                           i_comparator_async_output_enable,
  input  wire logic                           i_sysclk_enable,
  input  wire logic [1:0]                     i_capture_count,
  input  wire logic                           i_eci_enable,
  input  wire logic                           i_t0_enable,
  input  wire logic                           i_t1_enable,
  // event pin reach
  input  wire logic [pxb_pkg::PIN_IDX_W-1:0]  i_ext_int0_pin,
  input  wire logic [pxb_pkg::PIN_IDX_W-1:0]  i_ext_int1_pin,
  input  wire logic [P_NUM_PINS-1:0]          i_pin_match_mask,
  input  wire logic [P_NUM_PINS-1:0]          i_pin_match_value,
  // peripheral side
  input  wire logic                           i_uart_tx,
  input  wire logic [pxb_pkg::NUM_SLOTS-1:0]  i_slot_out,
  output logic                                o_uart_rx,
  output logic      [pxb_pkg::NUM_SLOTS-1:0]  o_slot_in,
  output logic      [pxb_pkg::NUM_SLOTS-1:0]  o_slot_placed,
  // pads
  input  wire logic [P_NUM_PINS-1:0]          i_pad,
  output logic      [P_NUM_PINS-1:0]          o_pad,
  output logic      [P_NUM_PINS-1:0]          o_pad_oe,
  output logic      [P_NUM_PINS-1:0]          o_pad_pullup,
  // status
  output logic      [P_NUM_PINS-1:0]          o_port_read,
  output logic                                o_ext_int0,
  output logic                                o_ext_int1,
  output logic                                o_pin_match,
  output logic                                o_pin_event
);
  import pxb_pkg::*;

  // ***********************************************
  // configuration state
  // ***********************************************
  logic [P_NUM_PINS-1:0] input_kind;
  logic [P_NUM_PINS-1:0] drive_style;
  logic [P_NUM_PINS-1:0] bypass;
  logic [P_NUM_PINS-1:0] port_latch;
  logic                  xbar_on;

  // all three masks load together so a pin never sees a mixed mode
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      input_kind  <= INPUT_KIND_RESET;
      drive_style <= DRIVE_RESET;
      bypass      <= BYPASS_RESET;
    end else if (i_cfg_write) begin
      input_kind  <= i_pin_input_kind_select;
      drive_style <= i_pin_drive_style_select;
      bypass      <= i_pin_bypass_mask;
    end
  end

  // registered so routing and drivers switch together on one edge
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      xbar_on <= 1'b0;
    end else begin
      xbar_on <= i_crossbar_route_enable;
    end
  end

  // latch resets to ones so open-drain pins float with pull-up
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      port_latch <= LATCH_RESET;
    end else if (i_latch_write) begin
      port_latch <= i_port_latch_wdata;
    end
  end

  // ***********************************************
  // priority crossbar
  // ***********************************************
  logic [NUM_SLOTS-1:0]  slot_want;
  logic [NUM_SLOTS-1:0]  slot_pair;
  logic [P_NUM_PINS-1:0] taken;
  logic [P_NUM_PINS-1:0] routed;
  logic [P_NUM_PINS-1:0] routed_out;
  logic [P_NUM_PINS-1:0] force_od;
  logic [PIN_IDX_W-1:0]  slot_pin [NUM_SLOTS];
  logic [NUM_SLOTS-1:0]  slot_ok;

  // capture channel n is routed when the count covers it
  function automatic logic cex_wanted(input logic [1:0] count,
                                      input int         chan);
    return int'(count) > chan;
  endfunction

  // enables form the request list in priority order
  always_comb begin
    slot_want                = '0;
    slot_want[SLOT_SPI_SCK]  = i_spi_enable;
    slot_want[SLOT_SPI_MISO] = i_spi_enable;
    slot_want[SLOT_SPI_MOSI] = i_spi_enable;
    slot_want[SLOT_SPI_NSS]  = i_spi_enable & i_spi_four_wire;
    slot_want[SLOT_SMB0_SDA] = i_smb0_enable;
    slot_want[SLOT_SMB0_SCL] = i_smb0_enable;
    slot_want[SLOT_CP0]      = i_cp0_enable;
    slot_want[SLOT_COMPARATOR_ASYNC_OUTPUT]     = i_comparator_async_output_enable;
    slot_want[SLOT_SYSCLK]   = i_sysclk_enable;
    slot_want[SLOT_CEX0]     = cex_wanted(i_capture_count, 0);
    slot_want[SLOT_CEX1]     = cex_wanted(i_capture_count, 1);
    slot_want[SLOT_CEX2]     = cex_wanted(i_capture_count, 2);
    slot_want[SLOT_ECI]      = i_eci_enable;
    slot_want[SLOT_T0]       = i_t0_enable;
    slot_want[SLOT_T1]       = i_t1_enable;
    slot_want[SLOT_SMB1_SDA] = i_smb1_enable;
    slot_want[SLOT_SMB1_SCL] = i_smb1_enable;
  end

  // first slot of each two-wire bus; its partner follows
  always_comb begin
    slot_pair                = '0;
    slot_pair[SLOT_SMB0_SDA] = 1'b1;
    slot_pair[SLOT_SMB1_SDA] = 1'b1;
  end

  // lowest free pin at or above a start index
  // top bit set in the result when no pin is left
  function automatic logic [PIN_IDX_W:0] first_free(input logic [P_NUM_PINS-1:0] busy,
                                                    input int                    from);
    logic [PIN_IDX_W:0] hit;
    hit = '1;
    for (int p = XBAR_PINS - 1; p >= 0; p--) begin
      if (p >= from && !busy[p]) begin
        hit = (PIN_IDX_W+1)'(p);
      end
    end
    return hit;
  endfunction

  // pure combinational walk so changes land in the same cycle
  always_comb begin
    logic [PIN_IDX_W:0] a;
    logic [PIN_IDX_W:0] b;
    a     = '1;
    b     = '1;
    taken = '0;
    // pin 20 never enters the walk; it doubles as debug data line
    for (int p = 0; p < P_NUM_PINS; p++) begin
      if (p >= XBAR_PINS) begin
        taken[p] = 1'b1;
      end
    end
    taken = taken | bypass;
    if (i_uart_enable) begin
      taken[UART_TX_PIN] = 1'b1;
      taken[UART_RX_PIN] = 1'b1;
    end
    slot_ok = '0;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      slot_pin[s] = '0;
    end
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (slot_want[s] && !(s > 0 && slot_pair[s-1])) begin
        a = first_free(taken, 0);
        if (slot_pair[s] && s + 1 < NUM_SLOTS) begin
          b = a[PIN_IDX_W] ? '1 : first_free(taken, int'(a[PIN_IDX_W-1:0]) + 1);
          if (!a[PIN_IDX_W] && !b[PIN_IDX_W]) begin
            slot_ok[s]      = 1'b1;
            slot_ok[s+1]    = 1'b1;
            slot_pin[s]     = a[PIN_IDX_W-1:0];
            slot_pin[s+1]   = b[PIN_IDX_W-1:0];
            taken[a[PIN_IDX_W-1:0]] = 1'b1;
            taken[b[PIN_IDX_W-1:0]] = 1'b1;
          end
        end else if (!a[PIN_IDX_W]) begin
          slot_ok[s]  = 1'b1;
          slot_pin[s] = a[PIN_IDX_W-1:0];
          taken[a[PIN_IDX_W-1:0]] = 1'b1;
        end
      end
    end
  end

  // two-wire bus pins are open-drain whatever the style bit says
  function automatic logic is_two_wire(input int slot);
    return slot == SLOT_SMB0_SDA || slot == SLOT_SMB0_SCL ||
           slot == SLOT_SMB1_SDA || slot == SLOT_SMB1_SCL;
  endfunction

  // pin-side view of the assignment
  always_comb begin
    routed     = '0;
    routed_out = '0;
    force_od   = '0;
    if (i_uart_enable) begin
      routed[UART_TX_PIN]     = 1'b1;
      routed_out[UART_TX_PIN] = i_uart_tx;
      routed[UART_RX_PIN]     = 1'b1;
      // style bit decides whether the receive pin floats or drives
      routed_out[UART_RX_PIN] = 1'b1;  // receive pin released high
    end
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (slot_ok[s]) begin
        routed[slot_pin[s]]     = 1'b1;
        routed_out[slot_pin[s]] = i_slot_out[s];
        if (is_two_wire(s)) begin
          force_od[slot_pin[s]] = 1'b1;  // two-wire buses always open-drain
        end
      end
    end
  end

  // ***********************************************
  // pin cells
  // ***********************************************
  logic [P_NUM_PINS-1:0] out_val;
  logic [P_NUM_PINS-1:0] digital_in;

  always_comb begin
    for (int p = 0; p < P_NUM_PINS; p++) begin
      out_val[p] = (xbar_on && routed[p]) ? routed_out[p] : port_latch[p];
      o_pad[p]   = out_val[p];
      // pin 20 also loses its drivers while the crossbar is off
      o_pad_oe[p] = 1'b0;
      if (xbar_on && input_kind[p]) begin
        if (drive_style[p] && !force_od[p]) begin
          o_pad_oe[p] = 1'b1;
        end else begin
          o_pad_oe[p] = !out_val[p];
        end
      end
      // pull-up only when released and digital
      o_pad_pullup[p] = input_kind[p] && !i_global_pullup_off && !o_pad_oe[p];
      // receiver gated off on analog pins
      digital_in[p]  = input_kind[p] & i_pad[p];
    end
  end

  // ***********************************************
  // read path
  // ***********************************************

  // synchronous read path; crossbar state never enters here
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_port_read <= '0;
    end else begin
      o_port_read <= digital_in;
    end
  end

  // ***********************************************
  // peripheral input side
  // ***********************************************

  always_comb begin
    o_uart_rx = i_uart_enable ? digital_in[UART_RX_PIN] : 1'b1;
    o_slot_in = '0;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (slot_ok[s] && xbar_on) begin
        o_slot_in[s] = digital_in[slot_pin[s]];
      end
    end
    o_slot_placed = xbar_on ? slot_ok : '0;
  end

  // ***********************************************
  // event triggers
  // ***********************************************
  logic [P_NUM_PINS-1:0] prev_in;
  logic                  match_now;
  logic [1:0]            warm;

  // pin-change event held off until the read path holds two real samples,
  // else the first read after reset looks like a pin change
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_in <= '0;
      warm    <= 2'h0;
    end else begin
      prev_in <= o_port_read;
      warm    <= {warm[0], 1'b1};
    end
  end

  // a level, not a pulse: stands while any masked pin differs
  // analog pins are masked off by their kind bits, so they can never trigger
  assign match_now = |((o_port_read ^ i_pin_match_value) & i_pin_match_mask & input_kind);

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ext_int0  <= 1'b0;
      o_ext_int1  <= 1'b0;
      o_pin_match <= 1'b0;
      o_pin_event <= 1'b0;
    end else begin
      o_ext_int0  <= o_port_read[i_ext_int0_pin] & input_kind[i_ext_int0_pin];
      o_ext_int1  <= o_port_read[i_ext_int1_pin] & input_kind[i_ext_int1_pin];
      o_pin_match <= match_now;
      o_pin_event <= warm[1] & (|((o_port_read ^ prev_in) & input_kind));
    end
  end
endmodule

// [sim/pxb_board_model.sv]
// board model: resolves every pad from cell drivers, board sources and pull-ups
module pxb_board_model #(
  parameter int P_N = 21
) (
  input  wire logic           i_clock,
  input  wire logic [P_N-1:0] i_drive,
  input  wire logic [P_N-1:0] i_drive_oe,
  input  wire logic [P_N-1:0] i_pullup,
  input  wire logic [P_N-1:0] i_ext_en,
  input  wire logic [P_N-1:0] i_ext_val,
  output logic      [P_N-1:0] o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [P_N-1:0] flt = '0;
  // undriven, unpulled pads wander so no read can lean on a held value
  always @(posedge i_clock) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < P_N; i++) begin
      o_level[i] = i_drive_oe[i] ? i_drive[i] : i_ext_en[i] ? i_ext_val[i] : i_pullup[i] ? 1'b1 : flt[i];
    end
  end
endmodule

// [sim/pxb_port_io_props.sv]
// checker for the port pin cells and crossbar
module pxb_port_io_props #(
  parameter int P_NUM_PINS = 21
) (
  input wire logic                  i_clock,
  input wire logic                  i_rstn,
  input wire logic                  i_cfg_write,
  input wire logic [P_NUM_PINS-1:0] i_pin_input_kind_select,
  input wire logic [P_NUM_PINS-1:0] i_pin_drive_style_select,
  input wire logic                  i_crossbar_route_enable,
  input wire logic                  i_global_pullup_off,
  input wire logic                  i_uart_enable,
  input wire logic                  i_uart_tx,
  input wire logic [P_NUM_PINS-1:0] i_pad,
  input wire logic [P_NUM_PINS-1:0] o_pad,
  input wire logic [P_NUM_PINS-1:0] o_pad_oe,
  input wire logic [P_NUM_PINS-1:0] o_pad_pullup,
  input wire logic [P_NUM_PINS-1:0] o_port_read,
  input wire logic                  o_pin_event,
  input wire logic [16:0]           o_slot_placed
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [P_NUM_PINS-1:0] kind;
  logic [P_NUM_PINS-1:0] style;
  // ***********************************************
  // stored pin modes, as the cells see them
  // ***********************************************
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      kind  <= '1;
      style <= '0;
    end else if (i_cfg_write) begin
      kind  <= i_pin_input_kind_select;
      style <= i_pin_drive_style_select;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  xbar_off_quiet_a: assert property (!$past(i_crossbar_route_enable) |->
    o_pad_oe[19:0] == '0 && o_slot_placed == '0) else $error("drivers active with crossbar off");
  analog_cell_off_a: assert property (((o_pad_oe | o_pad_pullup) & ~kind) == '0)
    else $error("analog pin drives or pulls up");
  analog_reads_zero_a: assert property ((o_port_read & ~kind & ~$past(kind)) == '0)
    else $error("analog pin reads one");
  open_drain_low_a: assert property ((o_pad_oe & ~style & o_pad) == '0)
    else $error("open-drain pin drives high");
  uart_tx_drive_a: assert property ($past(i_crossbar_route_enable) && i_uart_enable && style[4] && kind[4]
    |-> o_pad_oe[4] && o_pad[4] == i_uart_tx) else $error("serial transmit pin not driven");
  pullup_when_driving_a: assert property ((o_pad_pullup & o_pad_oe) == '0)
    else $error("pull-up on while driving");
  pullup_global_off_a: assert property (i_global_pullup_off |-> o_pad_pullup == '0)
    else $error("pull-up on while globally off");
  pad_read_back_a: assert property ($past(i_rstn) |->
    ((o_port_read ^ $past(i_pad)) & kind & $past(kind)) == '0)
    else $error("digital read differs from pad");
  event_needs_change_a: assert property ($past(o_port_read) == $past(o_port_read, 2) |-> !o_pin_event)
    else $error("event without pin change");
  cover property (o_pin_event);
  cover property ($past(i_crossbar_route_enable) && i_uart_enable);
  cover property (i_global_pullup_off && $past(i_crossbar_route_enable));
endmodule
bind pxb_port_io pxb_port_io_props #(.P_NUM_PINS(P_NUM_PINS)) u_props (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_cfg_write(i_cfg_write),
  .i_pin_input_kind_select(i_pin_input_kind_select), .i_pin_drive_style_select(i_pin_drive_style_select),
  .i_crossbar_route_enable(i_crossbar_route_enable), .i_global_pullup_off(i_global_pullup_off),
  .i_uart_enable(i_uart_enable), .i_uart_tx(i_uart_tx), .i_pad(i_pad), .o_pad(o_pad), .o_pad_oe(o_pad_oe),
  .o_pad_pullup(o_pad_pullup), .o_port_read(o_port_read), .o_pin_event(o_pin_event),
  .o_slot_placed(o_slot_placed));

// [sim/test_port_io_priority_crossbar.sv]
// self-checking bench for the port pin cells and crossbar
module test_port_io_priority_crossbar;
  timeunit 1ns;
  timeprecision 1ps;
  import pxb_pkg::*;
  logic i_clock = 1'b0, i_rstn = 1'b0, cfg_wr = 1'b0, latch_wr = 1'b0, xbar = 1'b0, pu_off = 1'b0;
  logic four = 1'b0, tx = 1'b0;
  logic [20:0] kind = '1, style = '0, bypass = '0, latch_d = '1, m_mask = '0, m_val = '0, ext_en = '0, ext_val = '0;
  logic [9:0]  en = '0;
  logic [1:0]  ncap = 2'h0;
  logic [4:0]  int0 = 5'h00;
  logic [16:0] slot_out = '0, slot_in, placed;
  logic [20:0] pad, o_pad, oe, pu, rd;
  logic        rx, int0_o, int1_o, match, ev;
  int n_mismatch = 0, samples_checked = 0, cycles = 0;
  pxb_port_io dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_pin_input_kind_select(kind),
    .i_pin_drive_style_select(style), .i_pin_bypass_mask(bypass), .i_cfg_write(cfg_wr),
    .i_port_latch_wdata(latch_d), .i_latch_write(latch_wr), .i_crossbar_route_enable(xbar),
    .i_global_pullup_off(pu_off), .i_uart_enable(en[0]), .i_spi_enable(en[1]), .i_spi_four_wire(four),
    .i_smb0_enable(en[2]), .i_smb1_enable(en[3]), .i_cp0_enable(en[4]), .i_comparator_async_output_enable(en[5]),
    .i_sysclk_enable(en[6]), .i_capture_count(ncap), .i_eci_enable(en[7]), .i_t0_enable(en[8]),
    .i_t1_enable(en[9]), .i_ext_int0_pin(int0), .i_ext_int1_pin(5'h08), .i_pin_match_mask(m_mask),
    .i_pin_match_value(m_val), .i_uart_tx(tx), .i_slot_out(slot_out), .o_uart_rx(rx), .o_slot_in(slot_in),
    .o_slot_placed(placed), .i_pad(pad), .o_pad(o_pad), .o_pad_oe(oe), .o_pad_pullup(pu), .o_port_read(rd),
    .o_ext_int0(int0_o), .o_ext_int1(int1_o), .o_pin_match(match), .o_pin_event(ev));
  pxb_board_model board (.i_clock(i_clock), .i_drive(o_pad), .i_drive_oe(oe), .i_pullup(pu),
    .i_ext_en(ext_en), .i_ext_val(ext_val), .o_level(pad));
  initial forever #12.5 i_clock = ~i_clock;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    @(negedge i_clock);
  endtask
  // three masks go in on one write strobe
  task automatic cfg(input logic [20:0] k, input logic [20:0] s, input logic [20:0] b);
    @(posedge i_clock);
    kind <= k;
    style <= s;
    bypass <= b;
    cfg_wr <= 1'b1;
    @(posedge i_clock);
    cfg_wr <= 1'b0;
    cyc(1);
  endtask
  task automatic results();
    $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // a hang ends in the same report
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      results();
    end
  end
  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    repeat (2) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(negedge i_clock);
    chk("oe after reset", oe, 0);
    chk("pullup after reset", pu, 21'h1fffff);
    cfg('1, ~21'h20, 21'h00000c);
    @(posedge i_clock);
    en <= '1;
    four <= 1'b1;
    ncap <= 2'h3;
    xbar <= 1'b1;
    slot_out <= 17'h04000;
    cyc(2);
    chk("placed full", placed, 17'h07fff);
    chk("pads full", o_pad[19:0] & ~20'h20, 20'hc000c);
    chk("oe full", oe[19:0] | 20'h20, 20'hfffff);
    @(posedge i_clock);
    en <= 10'h005;
    four <= 1'b0;
    ncap <= 2'h1;
    tx <= 1'b1;
    slot_out <= 17'h00220;
    ext_en <= 21'h20;
    ext_val <= '0;
    @(negedge i_clock);
    chk("placed example", placed, 17'h00230);
    chk("capture pin", {oe[6], o_pad[6], slot_in[SLOT_CEX0]}, 3'h7);
    chk("data pin low", {oe[0], o_pad[0], pu[0]}, 3'h4);
    chk("clock pin high", {oe[1], pu[1]}, 2'h1);
    chk("serial pins", {oe[4], o_pad[4], rx}, 3'h6);
    @(posedge i_clock);
    en <= '0;
    slot_out <= '0;
    ext_en <= 21'h180;
    ext_val <= 21'h080;
    cfg(~21'h80, '0, '0);
    chk("analog and digital read", rd[8:7], 2'h0);
    chk("analog cell", {oe[7], pu[7]}, 2'h0);
    @(posedge i_clock);
    ext_val <= 21'h180;
    int0 <= 5'h08;
    cyc(2);
    chk("event", {ev, rd[8]}, 2'h3);
    cyc(1);
    chk("event ends", {ev, int0_o, int1_o}, 3'h3);
    @(posedge i_clock);
    int0 <= 5'h07;
    m_mask <= 21'h180;
    m_val <= 21'h180;
    cyc(2);
    chk("analog events", {int0_o, match}, 2'h0);
    @(posedge i_clock);
    ext_en <= '0;
    latch_d <= ~21'h100;
    latch_wr <= 1'b1;
    @(posedge i_clock);
    latch_wr <= 1'b0;
    @(negedge i_clock);
    chk("latch low", {oe[8], o_pad[8], pu[8]}, 3'h4);
    @(posedge i_clock);
    xbar <= 1'b0;
    cyc(1);
    chk("match on low pin", match, 1);
    cyc(2);
    chk("crossbar off", oe[19:0], 0);
    chk("read with crossbar off", rd[8], 1);
    @(posedge i_clock);
    pu_off <= 1'b1;
    @(negedge i_clock);
    chk("pullups off", pu, 0);
    results();
  end
endmodule
